// ---- bench/itc_ctl_model.sv ----
`default_nettype none
module itc_ctl_model (
    // Wire levels
    input wire logic i_scl,
    input wire logic i_sda,
    // Low pulls the line, high releases it to the pull-up
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // Honours stretching, bounded so a stuck target cannot hang the run
    task automatic hi();
        o_scl = 1'b1;
        for (int k = 0; k < 3000 && i_scl !== 1'b1; k++) begin
            #10;
        end
        #60;
    endtask
    task automatic start();
        o_sda = 1'b1;
        hi();
        #40;
        o_sda = 1'b0;
        #80;
        o_scl = 1'b0;
        #60;
    endtask
    task automatic stop();
        o_sda = 1'b0;
        #40;
        hi();
        #40;
        o_sda = 1'b1;
        #80;
    endtask
    // Long low phase so the target can stretch before the clock is released
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            o_sda = tx[i];
            #40;
            hi();
            rx[i] = i_sda;
            o_scl = 1'b0;
            #60;
        end
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_itc_target.sv ----
`default_nettype none
module tb_itc_target;
    timeunit 1ns;
    timeprecision 1ns;
    import itc_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    itc_reg_req_t req = '0;
    logic collision_flag_p = 1'b0, be_p = 1'b0;
    logic [7:0] rdata, m_ca, v, own, d;
    logic scl_oe, sda_oe, scl_o, sda_o, m_scl, m_sda, data_irq, as_irq;
    logic [8:0] mr;
    logic [7:0] sent[$];
    bit m_dif, m_addr_stop_irq_flag, m_hold, m_rx, m_collision_flag, m_be, m_dir, m_ap;
    int mismatches = 0, checks_done = 0, cycles = 0;
    wire logic scl_w;
    wire logic sda_w;
    assign scl_w = m_scl & ~(scl_oe & ~scl_o);
    assign sda_w = m_sda & ~(sda_oe & ~sda_o);
    always #10 i_core_clk = ~i_core_clk;
    itc_target DUT (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_reg_req(req), .o_reg_rdata(rdata),
        .i_scl_in(scl_w), .o_scl_out(scl_o), .o_scl_oe(scl_oe),
        .i_sda_in(sda_w), .o_sda_out(sda_o), .o_sda_oe(sda_oe),
        .i_collision(collision_flag_p), .i_bus_error(be_p), .o_data_irq(data_irq), .o_addr_stop_irq(as_irq)
    );
    itc_ctl_model ctl (.i_scl(scl_w), .i_sda(sda_w), .o_scl(m_scl), .o_sda(m_sda));
    task automatic stop_test();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp, input string what);
        cmp8({7'h00, got}, {7'h00, exp}, what);
    endtask
    task automatic bus(input logic [7:0] a, input logic [7:0] dt, input logic w, input logic r);
        @(posedge i_core_clk);
        req <= {a, dt, w, r};
        @(posedge i_core_clk);
        req <= '0;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        bus(a, dt, 1'b1, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        bus(a, 8'h00, 1'b0, 1'b1);
        r = rdata;
    endtask
    function automatic logic [7:0] st();
        return {m_dif, m_addr_stop_irq_flag, m_hold & (m_dif | m_addr_stop_irq_flag), m_rx, m_collision_flag, m_be, m_dir, m_ap};
    endfunction
    task automatic chk_st();
        logic [7:0] s;
        rd(OFS_STATUS, s);
        cmp8(s, st(), "status");
        cmp1(data_irq, m_dif & m_ca[CA_DATA_IRQ_ENABLE], "data irq");
        cmp1(as_irq, m_addr_stop_irq_flag & m_ca[CA_AP_IEN], "addr/stop irq");
        cmp1(scl_oe, m_hold & (m_dif | m_addr_stop_irq_flag), "scl hold");
    endtask
    // Status reads have no side effects, so polling is safe
    task automatic poll(input int b);
        logic [7:0] s = '0;
        for (int k = 0; k < 300 && s[b] !== 1'b1; k++) begin
            rd(OFS_STATUS, s);
        end
        cmp1(s[b], 1'b1, "flag wait");
    endtask
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        m_ca = 8'h00;
        repeat (5) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        v = 8'($urandom(2810));
        own = 8'($urandom_range(8, 119));
        rd(OFS_CMD_CTRL, v);
        cmp8(v, 8'h00, "ctrl reset");
        chk_st();
        rd(8'h1f, v);
        cmp8(v, 8'h00, "unmapped read");
        wr(OFS_CMD_CTRL, 8'h05);
        rd(OFS_CMD_CTRL, v);
        cmp8(v, 8'h04, "ack bit kept, command reads zero");
        chk_st();
        wr(OFS_CMD_CTRL, 8'h00);
        wr(OFS_OWN_ADDR, {own[6:0], 1'b0});
        ctl.start();
        ctl.xfer({own[6:0], 2'b01}, mr);
        cmp1(mr[0], 1'b1, "disabled target answered");
        chk_st();
        ctl.stop();
        m_ca = 8'he1;
        wr(OFS_CTRL_A, m_ca);
        fork
            begin
                ctl.start();
                ctl.xfer({own[6:0], 2'b01}, mr);
            end
            begin
                poll(ST_ADDR_STOP_IRQ_FLAG);
                {m_addr_stop_irq_flag, m_hold, m_dir, m_ap} = 4'b1101;
                chk_st();
                for (int c = 0; c < 2; c++) begin
                    wr(OFS_CMD_CTRL, 8'(c));
                    chk_st();
                end
                wr(OFS_CMD_CTRL, 8'h03);
                {m_addr_stop_irq_flag, m_hold} = 2'b00;
            end
        join
        cmp1(mr[0], 1'b0, "address ack");
        chk_st();
        for (int j = 0; j < 2; j++) begin
            d = 8'($urandom);
            sent.push_back(d);
            fork
                ctl.xfer({d, 1'b1}, mr);
                begin
                    poll(ST_DIF);
                    {m_dif, m_hold} = 2'b11;
                    chk_st();
                    if (j == 0) begin
                        rd(OFS_DATA, v);
                        cmp8(v, sent.pop_front(), "received byte");
                    end else begin
                        wr(OFS_CMD_CTRL, 8'h06);
                    end
                    {m_dif, m_hold} = 2'b00;
                end
            join
            cmp1(mr[0], j[0], "ack action on bus");
            chk_st();
            if (j == 1) begin
                // Shift register keeps the byte once the transfer is completed
                rd(OFS_DATA, v);
                cmp8(v, sent.pop_front(), "byte kept after complete");
            end
        end
        ctl.stop();
        poll(ST_ADDR_STOP_IRQ_FLAG);
        {m_addr_stop_irq_flag, m_ap} = 2'b10;
        chk_st();
        wr(OFS_STATUS, 8'h40);
        m_addr_stop_irq_flag = 1'b0;
        chk_st();
        fork
            begin
                ctl.start();
                ctl.xfer({own[6:0], 2'b11}, mr);
                cmp1(mr[0], 1'b0, "read address ack");
                ctl.xfer(9'h1ff, mr);
            end
            begin
                poll(ST_ADDR_STOP_IRQ_FLAG);
                {m_addr_stop_irq_flag, m_hold, m_dir, m_ap} = 4'b1111;
                chk_st();
                wr(OFS_CMD_CTRL, 8'h03);
                m_addr_stop_irq_flag = 1'b0;
                poll(ST_DIF);
                m_dif = 1'b1;
                chk_st();
                d = 8'($urandom);
                wr(OFS_DATA, d);
                {m_dif, m_hold} = 2'b00;
                poll(ST_DIF);
                {m_dif, m_hold, m_rx} = 3'b111;
                chk_st();
                wr(OFS_CMD_CTRL, 8'h06);
                {m_dif, m_hold} = 2'b00;
            end
        join
        cmp8(mr[8:1], d, "transmitted byte");
        repeat (4) @(posedge i_core_clk);
        cmp1(sda_oe, 1'b0, "sda released after complete");
        ctl.stop();
        poll(ST_ADDR_STOP_IRQ_FLAG);
        {m_addr_stop_irq_flag, m_ap} = 2'b10;
        chk_st();
        wr(OFS_STATUS, 8'h40);
        m_addr_stop_irq_flag = 1'b0;
        for (int k = 2; k <= 3; k++) begin
            @(posedge i_core_clk);
            collision_flag_p <= (k == ST_COLLISION_FLAG);
            be_p <= (k == ST_BUS_ERROR_FLAG);
            @(posedge i_core_clk);
            {collision_flag_p, be_p} <= 2'b00;
            {m_collision_flag, m_be} = {k[0], ~k[0]};
            chk_st();
            wr(OFS_STATUS, 8'(1 << k));
            {m_collision_flag, m_be} = 2'b00;
            chk_st();
        end
        // Clearing the held address flag by hand gives up the transfer
        fork
            begin
                ctl.start();
                ctl.xfer({own[6:0], 2'b01}, mr);
            end
            begin
                poll(ST_ADDR_STOP_IRQ_FLAG);
                {m_addr_stop_irq_flag, m_hold, m_dir, m_ap} = 4'b1101;
                chk_st();
                wr(OFS_STATUS, 8'h40);
                {m_addr_stop_irq_flag, m_hold} = 2'b00;
                chk_st();
            end
        join
        cmp1(mr[0], 1'b1, "dropped address not acknowledged");
        ctl.stop();
        poll(ST_ADDR_STOP_IRQ_FLAG);
        {m_addr_stop_irq_flag, m_ap} = 2'b10;
        chk_st();
        stop_test();
    end
endmodule
`default_nettype wire

// ---- hw/itc_pkg.sv ----
`default_nettype none
package itc_pkg;
    // Register offsets
    localparam logic [7:0] OFS_CTRL_A = 8'h09;
    localparam logic [7:0] OFS_CMD_CTRL = 8'h0a;
    localparam logic [7:0] OFS_STATUS = 8'h0b;
    localparam logic [7:0] OFS_OWN_ADDR = 8'h0c;
    localparam logic [7:0] OFS_DATA = 8'h0d;
    // Field positions
    localparam int CA_EN = 0;
    localparam int CA_STOP_IEN = 5;
    localparam int CA_AP_IEN = 6;
    localparam int CA_DATA_IRQ_ENABLE = 7;
    localparam int CC_ACK = 2;
    localparam int ST_DIF = 7;
    localparam int ST_ADDR_STOP_IRQ_FLAG = 6;
    localparam int ST_COLLISION_FLAG = 3;
    localparam int ST_BUS_ERROR_FLAG = 2;
    // Reset values and counts
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [1:0] PIN_IDLE = 2'h3;
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;

    typedef enum logic [1:0] {
        CMD_NOP = 2'h0,
        CMD_RSVD = 2'h1,
        CMD_COMPLETE = 2'h2,
        CMD_RESPONSE = 2'h3
    } itc_cmd_t;

    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_ADDR = 9'h002,
        S_HOLD_A = 9'h004,
        S_ACK = 9'h008,
        S_RX = 9'h010,
        S_TX = 9'h020,
        S_RACK = 9'h040,
        S_HOLD_D = 9'h080,
        S_WAIT = 9'h100
    } itc_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } itc_reg_req_t;

    typedef struct packed {
        logic data_irq_flag;
        logic addr_stop_irq_flag;
        logic stretch;
        logic received_ack_bit;
        logic collision_flag;
        logic bus_error_flag;
        logic dir;
        logic ap;
    } itc_status_t;
endpackage
`default_nettype wire

// ---- hw/itc_target.sv ----
// Local design decision: strobed register access.
`default_nettype none
module itc_target (
    // System
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Register port
    input wire itc_pkg::itc_reg_req_t i_reg_req,
    output logic [7:0] o_reg_rdata,
    // Bus pins, open drain
    input wire logic i_scl_in,
    output logic o_scl_out,
    output logic o_scl_oe,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    // Error detectors
    input wire logic i_collision,
    input wire logic i_bus_error,
    // Interrupt requests
    output logic o_data_irq,
    output logic o_addr_stop_irq
);
    import itc_pkg::*;

    itc_state_t state_reg;
    logic [1:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
    logic [7:0] ctrl_a_reg, own_addr_reg, shift_reg;
    logic [3:0] bit_cnt_reg;
    logic ack_action_reg, ack_val_reg, ack_wait_reg;
    logic dif_reg, addr_stop_irq_flag_reg, received_ack_bit_reg, collision_flag_reg, bus_error_flag_reg, dir_reg, ap_reg;
    logic scl_rise, scl_fall, start_evt, stop_evt, en;
    logic wr_cmd, wr_stat, data_acc, valid_cmd, sw_clear, ack_now;
    logic holding, go_resp, go_done, hold_drop, byte_end;
    logic addr_hit, ack_dif, dif_set, stop_set;
    itc_cmd_t cmd;
    itc_status_t status;

    // Two flops before any logic looks at the pins
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_meta_reg <= PIN_IDLE;
            pin_sync_reg <= PIN_IDLE;
            pin_prev_reg <= PIN_IDLE;
        end else begin
            pin_meta_reg <= {i_sda_in, i_scl_in};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    assign scl_rise = pin_sync_reg[PIN_SCL] & ~pin_prev_reg[PIN_SCL];
    assign scl_fall = ~pin_sync_reg[PIN_SCL] & pin_prev_reg[PIN_SCL];
    assign start_evt = en & pin_sync_reg[PIN_SCL] & pin_prev_reg[PIN_SCL]
        & ~pin_sync_reg[PIN_SDA] & pin_prev_reg[PIN_SDA];
    assign stop_evt = pin_sync_reg[PIN_SCL] & pin_prev_reg[PIN_SCL]
        & pin_sync_reg[PIN_SDA] & ~pin_prev_reg[PIN_SDA];

    assign en = ctrl_a_reg[CA_EN];
    assign cmd = itc_cmd_t'(i_reg_req.wdata[1:0]);
    assign wr_cmd = i_reg_req.wr && i_reg_req.addr == OFS_CMD_CTRL;
    assign wr_stat = i_reg_req.wr && i_reg_req.addr == OFS_STATUS;
    assign data_acc = (i_reg_req.wr || i_reg_req.rd) && i_reg_req.addr == OFS_DATA;
    // No-op and reserved codes are not valid, so they clear nothing
    assign valid_cmd = wr_cmd && (cmd == CMD_COMPLETE || cmd == CMD_RESPONSE);
    assign sw_clear = valid_cmd || data_acc;
    // A command write uses the ack value written beside it
    assign ack_now = wr_cmd ? i_reg_req.wdata[CC_ACK] : ack_action_reg;
    assign holding = state_reg == S_HOLD_A || state_reg == S_HOLD_D;
    assign go_resp = holding && (data_acc || (wr_cmd && cmd == CMD_RESPONSE));
    assign go_done = holding && wr_cmd && cmd == CMD_COMPLETE;
    // Clearing the held flag by hand gives up the transfer
    assign hold_drop = holding && wr_stat
        && (i_reg_req.wdata[ST_DIF] || i_reg_req.wdata[ST_ADDR_STOP_IRQ_FLAG]);
    assign byte_end = scl_fall && bit_cnt_reg == BYTE_BITS;
    assign addr_hit = state_reg == S_ADDR && byte_end
        && shift_reg[7:1] == own_addr_reg[7:1];
    assign ack_dif = state_reg == S_ACK && scl_fall && !ack_val_reg
        && !ack_wait_reg && dir_reg;
    assign dif_set = (state_reg == S_RX && byte_end)
        || (state_reg == S_RACK && scl_fall) || ack_dif;
    assign stop_set = stop_evt && en && ctrl_a_reg[CA_STOP_IEN]
        && state_reg != S_IDLE;

    // Transaction sequencer
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= S_IDLE;
            bit_cnt_reg <= CNT_RESET;
            ack_val_reg <= 1'b0;
            ack_wait_reg <= 1'b0;
        end else if (!en) begin
            state_reg <= S_IDLE;
        end else if (start_evt) begin
            state_reg <= S_ADDR;
            bit_cnt_reg <= CNT_RESET;
        end else if (stop_evt) begin
            state_reg <= S_IDLE;
        end else begin
            case (state_reg)
                S_ADDR, S_RX: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    if (byte_end) begin
                        if (state_reg == S_RX || addr_hit) begin
                            state_reg <= state_reg == S_RX ? S_HOLD_D : S_HOLD_A;
                        end else begin
                            state_reg <= S_WAIT;
                        end
                    end
                end
                S_HOLD_A, S_HOLD_D: begin
                    if (go_done && !dir_reg) begin
                        state_reg <= S_ACK;
                        ack_val_reg <= ack_now;
                        ack_wait_reg <= 1'b1;
                    end else if (go_done || hold_drop) begin
                        state_reg <= S_WAIT;
                    end else if (go_resp && dir_reg && state_reg == S_HOLD_D) begin
                        state_reg <= S_TX;
                        bit_cnt_reg <= CNT_RESET;
                    end else if (go_resp) begin
                        state_reg <= S_ACK;
                        ack_val_reg <= ack_now;
                        ack_wait_reg <= 1'b0;
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= CNT_RESET;
                        if (ack_val_reg || ack_wait_reg) begin
                            state_reg <= S_WAIT;
                        end else begin
                            state_reg <= dir_reg ? S_HOLD_D : S_RX;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == BYTE_LAST) begin
                            state_reg <= S_RACK;
                        end
                    end
                end
                S_RACK: begin
                    if (scl_fall) begin
                        state_reg <= S_HOLD_D;
                    end
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // Shift register; writes only land while the clock is held
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            shift_reg <= BYTE_RESET;
        end else if (i_reg_req.wr && i_reg_req.addr == OFS_DATA && holding) begin
            shift_reg <= i_reg_req.wdata;
        end else if (scl_rise && (state_reg == S_ADDR || state_reg == S_RX)) begin
            shift_reg <= {shift_reg[6:0], pin_sync_reg[PIN_SDA]};
        end else if (scl_fall && state_reg == S_TX) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
        end
    end

    // Bus-side status bits
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            received_ack_bit_reg <= 1'b0;
            dir_reg <= 1'b0;
            ap_reg <= 1'b0;
        end else begin
            if (state_reg == S_RACK && scl_rise) begin
                received_ack_bit_reg <= pin_sync_reg[PIN_SDA];
            end
            if (addr_hit) begin
                dir_reg <= shift_reg[0];
            end
            if (addr_hit) begin
                ap_reg <= 1'b1;
            end else if (stop_set) begin
                ap_reg <= 1'b0;
            end
        end
    end

    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dif_reg <= 1'b0;
            addr_stop_irq_flag_reg <= 1'b0;
            collision_flag_reg <= 1'b0;
            bus_error_flag_reg <= 1'b0;
        end else begin
            dif_reg <= dif_set || (dif_reg && !sw_clear
                && !(wr_stat && i_reg_req.wdata[ST_DIF]));
            addr_stop_irq_flag_reg <= addr_hit || stop_set || (addr_stop_irq_flag_reg && !sw_clear
                && !(wr_stat && i_reg_req.wdata[ST_ADDR_STOP_IRQ_FLAG]));
            collision_flag_reg <= i_collision || (collision_flag_reg && !start_evt
                && !(wr_stat && i_reg_req.wdata[ST_COLLISION_FLAG]));
            bus_error_flag_reg <= i_bus_error || (bus_error_flag_reg
                && !(wr_stat && i_reg_req.wdata[ST_BUS_ERROR_FLAG]));
        end
    end

    // Software control registers
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_a_reg <= BYTE_RESET;
            own_addr_reg <= BYTE_RESET;
            ack_action_reg <= 1'b0;
        end else if (i_reg_req.wr) begin
            if (i_reg_req.addr == OFS_CTRL_A) begin
                ctrl_a_reg <= i_reg_req.wdata;
            end else if (i_reg_req.addr == OFS_OWN_ADDR) begin
                own_addr_reg <= i_reg_req.wdata;
            end else if (i_reg_req.addr == OFS_CMD_CTRL) begin
                ack_action_reg <= i_reg_req.wdata[CC_ACK];
            end
        end
    end

    always_comb begin
        status = '0;
        status.data_irq_flag = dif_reg;
        status.addr_stop_irq_flag = addr_stop_irq_flag_reg;
        status.stretch = holding && (dif_reg || addr_stop_irq_flag_reg);
        status.received_ack_bit = received_ack_bit_reg;
        status.collision_flag = collision_flag_reg;
        status.bus_error_flag = bus_error_flag_reg;
        status.dir = dir_reg;
        status.ap = ap_reg;
    end

    // Read data valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata <= BYTE_RESET;
        end else if (!i_reg_req.rd) begin
            o_reg_rdata <= BYTE_RESET;
        end else if (i_reg_req.addr == OFS_CTRL_A) begin
            o_reg_rdata <= ctrl_a_reg;
        end else if (i_reg_req.addr == OFS_CMD_CTRL) begin
            o_reg_rdata <= {5'h00, ack_action_reg, 2'h0};
        end else if (i_reg_req.addr == OFS_STATUS) begin
            o_reg_rdata <= status;
        end else if (i_reg_req.addr == OFS_OWN_ADDR) begin
            o_reg_rdata <= own_addr_reg;
        end else if (i_reg_req.addr == OFS_DATA) begin
            o_reg_rdata <= shift_reg;
        end else begin
            o_reg_rdata <= BYTE_RESET;
        end
    end

    // Pins only ever pull low; collision silences SDA
    assign o_scl_out = 1'b0;
    assign o_sda_out = 1'b0;
    assign o_scl_oe = holding;
    assign o_sda_oe = en && !collision_flag_reg && ((state_reg == S_ACK && !ack_val_reg)
        || (state_reg == S_TX && !shift_reg[7]));
    assign o_data_irq = dif_reg && ctrl_a_reg[CA_DATA_IRQ_ENABLE];
    assign o_addr_stop_irq = addr_stop_irq_flag_reg && ctrl_a_reg[CA_AP_IEN];

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    property p_disabled_idle;
        !en |=> state_reg == S_IDLE && !o_scl_oe && !o_sda_oe;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("enabled off");
    property p_cmd_reads_zero;
        i_reg_req.rd && i_reg_req.addr == OFS_CMD_CTRL |=> o_reg_rdata[1:0] == 2'h0
            && o_reg_rdata[CC_ACK] == ack_action_reg;
    endproperty
    a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("cmd readback");
    property p_ack_stored;
        !(i_reg_req.wr && i_reg_req.addr == OFS_CMD_CTRL) |=> $stable(ack_action_reg);
    endproperty
    a_ack_stored: assert property (p_ack_stored) else $error("ack bit moved");
    property p_access_clears;
        data_acc && !dif_set && !addr_hit && !stop_set |=> !dif_reg && !addr_stop_irq_flag_reg;
    endproperty
    a_access_clears: assert property (p_access_clears) else $error("flags kept");
    property p_rx_sets_dif;
        state_reg == S_RX && byte_end && en && !start_evt && !stop_evt
            |=> dif_reg && o_scl_oe [*2];
    endproperty
    a_rx_sets_dif: assert property (p_rx_sets_dif) else $error("rx no dif");
    property p_irq_gate;
        dif_set && ctrl_a_reg[CA_DATA_IRQ_ENABLE] && !(i_reg_req.wr && i_reg_req.addr == OFS_CTRL_A)
            |=> o_data_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq gate");
    property p_complete_write;
        holding && go_done && !dir_reg && en && !start_evt && !stop_evt
            |=> state_reg == S_ACK && ack_val_reg == $past(i_reg_req.wdata[CC_ACK]);
    endproperty
    a_complete_write: assert property (p_complete_write) else $error("no ack");
    property p_complete_read;
        holding && go_done && dir_reg && en && !start_evt && !stop_evt
            |=> state_reg == S_WAIT && !o_sda_oe;
    endproperty
    a_complete_read: assert property (p_complete_read) else $error("read end");
    property p_reserved_nop;
        wr_cmd && !cmd[1] && holding && en && !start_evt && !stop_evt && !dif_set
            |=> $stable(state_reg) && $stable(dif_reg) && o_scl_oe;
    endproperty
    a_reserved_nop: assert property (p_reserved_nop) else $error("reserved acted");
    property p_addr_cause;
        addr_hit && en && !stop_evt && !start_evt |=> addr_stop_irq_flag_reg && ap_reg && o_scl_oe;
    endproperty
    a_addr_cause: assert property (p_addr_cause) else $error("cause bit");

    c_addr_hit: cover property (addr_hit ##[1:300] state_reg == S_RX);
    c_tx_byte: cover property (state_reg == S_TX ##[1:1000] state_reg == S_HOLD_D);
    c_stop: cover property (stop_set);
endmodule
`default_nettype wire
